// file: verilog/mon_alert_regs.svh
// Register offsets, field positions, reset values and timing figures
// Assumes inclusion by bare name from the alert and address block
`ifndef MON_ALERT_REGS_SVH
`define MON_ALERT_REGS_SVH

// ----------------------------------------------------------------
// Register pointer values
// ----------------------------------------------------------------
`define OFS_SETUP     3'h0
`define OFS_SHUNT     3'h1
`define OFS_RAIL      3'h2
`define OFS_POWER     3'h3
`define OFS_CURRENT   3'h4
`define OFS_SCALE     3'h5
`define OFS_SRC_SEL   3'h6
`define OFS_THRESHOLD 3'h7

// ----------------------------------------------------------------
// Source-select fields
// ----------------------------------------------------------------
`define SRC_EN_MSB    15
`define SRC_EN_LSB    10
`define SRC_LIMIT_BIT 4
`define SRC_READY_BIT 3
`define SRC_CONVERSION_READY_ENABLE_IDX  0

// ----------------------------------------------------------------
// Reset values and bus constants
// ----------------------------------------------------------------
`define SETUP_RST     16'h0000
`define SCALE_RST     16'h0000
`define THRESH_RST    16'h0000
`define SRC_EN_RST    6'h00
`define ADDR_PREFIX   3'h4
`define ALERT_RSP_ADR 7'h0c
`define SCL_FS_MAX_KHZ 2940
`define SYS_CLK_KHZ   50000
`define SCL_SAMPLES_MIN (`SYS_CLK_KHZ / (2 * `SCL_FS_MAX_KHZ))

`endif

// file: verilog/mon_alert_pkg.sv
// Types shared by the alert and address block
// Assumes nothing beyond a SystemVerilog compiler
package mon_alert_pkg;

  // Serial bit engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100
  } bus_state_t;

  // Meaning of the byte in flight
  typedef enum logic [2:0] {
    RL_ADDR = 3'b000,
    RL_PTR  = 3'b001,
    RL_DATA = 3'b010,
    RL_RD   = 3'b011,
    RL_ARA  = 3'b100
  } byte_role_t;

  // Conversion results from the measurement path
  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] rail;
    logic [15:0] power;
    logic [15:0] current;
  } results_t;

endpackage : mon_alert_pkg

// file: verilog/mon_alert.sv
// Serial-bus register slave, strap address decode and alert output
// Assumes results and conversion-done pulse arrive on SYS_CLK; bus pins are async
`timescale 1ns/100ps
`include "mon_alert_regs.svh"

// Functional notes
// - Enabled quantity beyond threshold pulls alert low
// - Five limit events: shunt/rail over/under, power over
// - Highest enabled event bit alone is compared
// - Comparison is signed two's complement
// - Ready notice and limit event share alert
// - Ready flag bit 3, limit flag bit 4
// - Ready enable clear: alert from limit only
// - Ready flagged when conversion has completed
// - Bus clock 1-400 kHz fast, 1-2940 kHz high-speed
// - Sixteen addresses from two four-state straps
// - Address 100, high strap, low strap codes
// - Straps sampled at every bus transaction
// - Alert released after own address returned
// - Losing arbitration: no ack, alert held
// - Pointer kept from last write, MSB first
module mon_alert (
  input  wire logic                      SYS_CLK,
  input  wire logic                      RST_N,
  input  wire logic                      SCL_I,
  input  wire logic                      SDA_I,
  output logic                           SDA_O,
  output logic                           SDA_OE_N,
  output logic                           ALERT_O,
  output logic                           ALERT_OE_N,
  input  wire logic [1:0]                ADDR_STRAP_HIGH,
  input  wire logic [1:0]                ADDR_STRAP_LOW,
  input  wire mon_alert_pkg::results_t   RESULTS,
  input  wire logic                      CONV_DONE,
  output logic [15:0]                    SETUP,
  output logic [15:0]                    SCALE
);

  // ----------------------------------------------------------------
  // Signed compare helper
  // ----------------------------------------------------------------
  // Sign bit counts, so any positive value beats any negative one
  function automatic logic above(input logic [15:0] a, input logic [15:0] b);
    above = $signed(a) > $signed(b);
  endfunction : above

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic                      rst_s1_r;
  logic                      rst_n;
  logic                      scl_s1_r, scl_s2_r, scl_q_r;
  logic                      sda_s1_r, sda_s2_r, sda_q_r;
  logic [3:0]                strap_s1_r, strap_s2_r;

  // Reset asserts at once, releases two clocks later
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // Pins pass two flops; a third copy gives edge history
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {scl_s1_r, scl_s2_r, scl_q_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_q_r} <= 3'h7;
      strap_s1_r <= 4'h0;
      strap_s2_r <= 4'h0;
    end
    else
    begin
      {scl_s1_r, scl_s2_r, scl_q_r} <= {SCL_I, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_q_r} <= {SDA_I, sda_s1_r, sda_s2_r};
      strap_s1_r <= {ADDR_STRAP_HIGH, ADDR_STRAP_LOW};
      strap_s2_r <= strap_s1_r;
    end
  end

  // Bus events; 50 MHz sampling keeps several samples per high-speed phase
  wire bus_start = scl_s2_r & sda_q_r & ~sda_s2_r;
  wire bus_stop  = scl_s2_r & ~sda_q_r & sda_s2_r;
  wire scl_rise  = scl_s2_r & ~scl_q_r;
  wire scl_fall  = ~scl_s2_r & scl_q_r;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mon_alert_pkg::bus_state_t state_r, state_nxt;
  mon_alert_pkg::byte_role_t role_r, role_nxt;
  logic [3:0]                cnt_r, cnt_nxt;
  logic [7:0]                shift_r, shift_nxt;
  logic [7:0]                tx_r, tx_nxt;
  logic [2:0]                ptr_r, ptr_nxt;
  logic [7:0]                hi_r, hi_nxt;
  logic                      lsb_r, lsb_nxt;
  logic                      sda_oe_n_r, sda_oe_n_nxt;
  logic [6:0]                dev_addr_r;
  logic [15:0]               setup_r, scale_r, thresh_r;
  logic [5:0]                src_en_r;
  logic                      ready_r, limit_r, want_q_r, alert_oe_n_r;
  logic [15:0]               rd_word;
  logic [7:0]                tx_load;

  // ----------------------------------------------------------------
  // Decodes feeding the register file and alert
  // ----------------------------------------------------------------
  wire rx_done   = (state_r == mon_alert_pkg::ST_RX) & scl_fall & (cnt_r == 4'h8);
  wire own_hit   = shift_r[7:1] == dev_addr_r;
  wire ara_hit   = (shift_r[7:1] == `ALERT_RSP_ADR) & shift_r[0] & ~alert_oe_n_r;
  wire wr_commit = rx_done & (role_r == mon_alert_pkg::RL_DATA) & lsb_r;
  wire [15:0] wr_data = {hi_r, shift_r};
  wire ack_fall  = (state_r == mon_alert_pkg::ST_ACK) & scl_fall;
  wire rd_src    = ack_fall & (role_r == mon_alert_pkg::RL_RD) & lsb_r &
                   (ptr_r == `OFS_SRC_SEL);
  wire ara_done  = (state_r == mon_alert_pkg::ST_TX) & scl_fall & (cnt_r == 4'h8) &
                   (role_r == mon_alert_pkg::RL_ARA);
  wire tx_lost   = (state_r == mon_alert_pkg::ST_TX) & scl_rise &
                   (role_r == mon_alert_pkg::RL_ARA) & tx_r[7] & ~sda_s2_r;

  // Readback; source-select shows enables plus both flags
  always_comb
  begin
    case (ptr_r)
      `OFS_SETUP:     rd_word = setup_r;
      `OFS_SHUNT:     rd_word = RESULTS.shunt;
      `OFS_RAIL:      rd_word = RESULTS.rail;
      `OFS_POWER:     rd_word = RESULTS.power;
      `OFS_CURRENT:   rd_word = RESULTS.current;
      `OFS_SCALE:     rd_word = scale_r;
      `OFS_SRC_SEL:   rd_word = {src_en_r, 5'h00, limit_r, ready_r, 3'h0};
      default:        rd_word = thresh_r;
    endcase
  end

  // Answer byte: own address for alert response, else MSB then LSB
  assign tx_load = (role_r == mon_alert_pkg::RL_ARA) ? {dev_addr_r, 1'b0} :
                   (lsb_r ? rd_word[7:0] : rd_word[15:8]);

  // ----------------------------------------------------------------
  // Bit engine next state
  // ----------------------------------------------------------------
  // Changes to SDA happen only after SCL is seen low, giving hold margin
  always_comb
  begin
    state_nxt    = state_r;
    role_nxt     = role_r;
    cnt_nxt      = cnt_r;
    shift_nxt    = shift_r;
    tx_nxt       = tx_r;
    ptr_nxt      = ptr_r;
    hi_nxt       = hi_r;
    lsb_nxt      = lsb_r;
    sda_oe_n_nxt = sda_oe_n_r;
    if (bus_start)
    begin
      state_nxt    = mon_alert_pkg::ST_RX;
      role_nxt     = mon_alert_pkg::RL_ADDR;
      cnt_nxt      = 4'h0;
      sda_oe_n_nxt = 1'b1;
    end
    else if (bus_stop)
    begin
      state_nxt    = mon_alert_pkg::ST_IDLE;
      sda_oe_n_nxt = 1'b1;
    end
    else
    begin
      case (state_r)
        mon_alert_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda_s2_r};
            cnt_nxt   = cnt_r + 4'h1;
          end
          else if (rx_done)
          begin
            state_nxt    = mon_alert_pkg::ST_ACK;
            sda_oe_n_nxt = 1'b0;
            cnt_nxt      = 4'h0;
            case (role_r)
              mon_alert_pkg::RL_ADDR:
              begin
                lsb_nxt = 1'b0;
                if (own_hit)
                  role_nxt = shift_r[0] ? mon_alert_pkg::RL_RD : mon_alert_pkg::RL_PTR;
                else if (ara_hit)
                  role_nxt = mon_alert_pkg::RL_ARA;
                else
                begin
                  state_nxt    = mon_alert_pkg::ST_IDLE;
                  sda_oe_n_nxt = 1'b1;
                end
              end
              mon_alert_pkg::RL_PTR:
              begin
                ptr_nxt  = shift_r[2:0];
                role_nxt = mon_alert_pkg::RL_DATA;
              end
              default:
              begin
                hi_nxt  = lsb_r ? hi_r : shift_r;
                lsb_nxt = ~lsb_r;
              end
            endcase
          end
        end
        mon_alert_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            cnt_nxt = 4'h0;
            if ((role_r == mon_alert_pkg::RL_RD) || (role_r == mon_alert_pkg::RL_ARA))
            begin
              state_nxt    = mon_alert_pkg::ST_TX;
              tx_nxt       = tx_load;
              sda_oe_n_nxt = tx_load[7];
            end
            else
            begin
              state_nxt    = mon_alert_pkg::ST_RX;
              sda_oe_n_nxt = 1'b1;
            end
          end
        end
        mon_alert_pkg::ST_TX:
        begin
          if (tx_lost)
          begin
            state_nxt    = mon_alert_pkg::ST_IDLE;
            sda_oe_n_nxt = 1'b1;
          end
          else if (scl_rise)
            cnt_nxt = cnt_r + 4'h1;
          else if (scl_fall && (cnt_r == 4'h8))
          begin
            state_nxt    = mon_alert_pkg::ST_MACK;
            sda_oe_n_nxt = 1'b1;
          end
          else if (scl_fall)
          begin
            tx_nxt       = {tx_r[6:0], 1'b0};
            sda_oe_n_nxt = tx_r[6];
          end
        end
        mon_alert_pkg::ST_MACK:
        begin
          // Master ack fetches the other byte; nack or response end stops
          if (scl_rise)
          begin
            if (sda_s2_r || (role_r == mon_alert_pkg::RL_ARA))
              state_nxt = mon_alert_pkg::ST_IDLE;
            else
            begin
              state_nxt = mon_alert_pkg::ST_ACK;
              lsb_nxt   = ~lsb_r;
            end
          end
        end
        default:
          state_nxt = mon_alert_pkg::ST_IDLE;
      endcase
    end
  end

  // Bit engine registers
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r    <= mon_alert_pkg::ST_IDLE;
      role_r     <= mon_alert_pkg::RL_ADDR;
      cnt_r      <= 4'h0;
      shift_r    <= 8'h00;
      tx_r       <= 8'h00;
      ptr_r      <= `OFS_SETUP;
      hi_r       <= 8'h00;
      lsb_r      <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end
    else
    begin
      state_r    <= state_nxt;
      role_r     <= role_nxt;
      cnt_r      <= cnt_nxt;
      shift_r    <= shift_nxt;
      tx_r       <= tx_nxt;
      ptr_r      <= ptr_nxt;
      hi_r       <= hi_nxt;
      lsb_r      <= lsb_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Strap address
  // ----------------------------------------------------------------
  // Straps are re-read at every start, never frozen at power-up
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      dev_addr_r <= {`ADDR_PREFIX, 4'h0};
    else if (bus_start)
      dev_addr_r <= {`ADDR_PREFIX, strap_s2_r};
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setup_r  <= `SETUP_RST;
      scale_r  <= `SCALE_RST;
      thresh_r <= `THRESH_RST;
      src_en_r <= `SRC_EN_RST;
    end
    else if (wr_commit)
    begin
      case (ptr_r)
        `OFS_SETUP:     setup_r  <= wr_data;
        `OFS_SCALE:     scale_r  <= wr_data;
        `OFS_SRC_SEL:   src_en_r <= wr_data[`SRC_EN_MSB:`SRC_EN_LSB];
        `OFS_THRESHOLD: thresh_r <= wr_data;
        default:        setup_r  <= setup_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Limit comparison and alert
  // ----------------------------------------------------------------
  // Highest enabled bit wins; threshold is taken raw on the result's scale
  wire limit_now = src_en_r[5] ?  above(RESULTS.shunt, thresh_r) :
                   src_en_r[4] ?  above(thresh_r, RESULTS.shunt) :
                   src_en_r[3] ?  above(RESULTS.rail, thresh_r)  :
                   src_en_r[2] ?  above(thresh_r, RESULTS.rail)  :
                   src_en_r[1] ?  above(RESULTS.power, thresh_r) : 1'b0;
  // Ready only counts when its enable is set
  wire want = limit_r | (src_en_r[`SRC_CONVERSION_READY_ENABLE_IDX] & ready_r);
  wire new_evt = want & ~want_q_r;

  // Flags: ready set wins over the clear from reading source-select
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_r  <= 1'b0;
      limit_r  <= 1'b0;
      want_q_r <= 1'b0;
    end
    else
    begin
      ready_r  <= CONV_DONE | (ready_r & ~rd_src);
      limit_r  <= CONV_DONE ? limit_now : limit_r;
      want_q_r <= want;
    end
  end

  // Pin held low while a cause stands until the response is won
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      alert_oe_n_r <= 1'b1;
    else if (new_evt)
      alert_oe_n_r <= 1'b0;
    else if (ara_done || !want)
      alert_oe_n_r <= 1'b1;
  end

  assign SDA_O      = 1'b0;
  assign ALERT_O    = 1'b0;
  assign SDA_OE_N   = sda_oe_n_r;
  assign ALERT_OE_N = alert_oe_n_r;
  assign SETUP      = setup_r;
  assign SCALE      = scale_r;

endmodule : mon_alert

// file: test/mon_alert_sva.sv
// Port checks for the alert and serial address block
// Assumes binding to mon_alert; sees only its ports
`timescale 1ns/100ps
module mon_alert_sva (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        SCL_I,
  input wire logic        SDA_O,
  input wire logic        SDA_OE_N,
  input wire logic        ALERT_O,
  input wire logic        ALERT_OE_N,
  input wire logic        CONV_DONE,
  input wire logic [15:0] SETUP
);
  // ----
  // Clocking
  // ----
  default clocking chk_cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // Open-drain pins only ever pull low
  a_sda_open_drain: assert property (SDA_O == 1'b0)
    else $error("data pin value not low");
  a_alert_open_drain: assert property (ALERT_O == 1'b0)
    else $error("alert pin value not low");
  // Both pins released for two edges after reset lifts
  a_quiet_after_reset: assert property ($rose(RST_N) |-> (SDA_OE_N && ALERT_OE_N) [*2])
    else $error("pin driven right after reset");
  // Data drive moves only in the clock low phase, else it forms a start or stop
  a_sda_low_phase: assert property ($changed(SDA_OE_N) |-> !$past(SCL_I, 2))
    else $error("data drive changed with clock high");
  // A driven low bit stands for at least six clocks
  a_bit_holds: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N [*6])
    else $error("driven bit too short");
  // Writes land on the clock fall after the last data bit
  a_setup_commit: assert property ($changed(SETUP) |-> !$past(SCL_I, 2))
    else $error("setup changed outside a write");
  // Alert asserts only from a conversion or a bus write
  a_alert_cause: assert property ($fell(ALERT_OE_N) |-> $past(CONV_DONE, 2) || !$past(SCL_I, 2))
    else $error("alert asserted without cause");
  // Alert releases only from a conversion or bus service
  a_alert_release: assert property ($rose(ALERT_OE_N) |-> $past(CONV_DONE, 2) || !$past(SCL_I, 2))
    else $error("alert released without cause");

  c_alert_set: cover property ($fell(ALERT_OE_N));
  c_alert_clear: cover property ($rose(ALERT_OE_N) && !$past(SCL_I, 2));
  c_ack_drive: cover property ($fell(SDA_OE_N));
endmodule : mon_alert_sva

bind mon_alert mon_alert_sva mon_alert_sva_inst (
  .SYS_CLK    (SYS_CLK),
  .RST_N      (RST_N),
  .SCL_I      (SCL_I),
  .SDA_O      (SDA_O),
  .SDA_OE_N   (SDA_OE_N),
  .ALERT_O    (ALERT_O),
  .ALERT_OE_N (ALERT_OE_N),
  .CONV_DONE  (CONV_DONE),
  .SETUP      (SETUP)
);

// file: test/host.sv
// Serial bus host model: drives clock and pulls data low
// Assumes the bench resolves the data wire with a pull-up
`timescale 1ns/100ps
module host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Idle bus: clock high, data released
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // One bit, 160 ns: low 5 cycles, high 3; sampled before the next fall
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk) scl <= 1'b0;
    repeat (2) @(posedge clk);
    sda_low <= !b;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk) r = sda;
  endtask : bit_io

  // Start (a=0) or stop (a=1); long low phase lets the slave drop its ack
  task automatic cond(input logic a);
    @(posedge clk) scl <= 1'b0;
    repeat (2) @(posedge clk);
    sda_low <= a;
    repeat (6) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sda_low <= !a;
    repeat (4) @(posedge clk);
  endtask : cond

  // Byte out, MSB first, then the slave's acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : send

  // Byte in; mine holds a rival's bits for arbitration, last sends no-ack
  task automatic recv(input logic [7:0] mine, input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(mine[i], d[i]);
    bit_io(last, r);
  endtask : recv
endmodule : host

// file: test/tb.sv
// Self-checking bench for the alert and serial address block
// Assumes the host model drives the bus; pull-up modelled here
`timescale 1ns/100ps
module tb;
  logic                    clk;
  logic                    rst_n;
  logic                    scl;
  logic                    sda_low;
  wire logic               sda;
  logic                    sda_oe_n;
  logic                    alert_oe_n;
  logic                    sda_o;
  logic                    alert_o;
  wire logic               alert;
  logic [1:0]              strap_h;
  logic [1:0]              strap_l;
  mon_alert_pkg::results_t res;
  logic                    conv_done;
  logic [15:0]             setup;
  logic [15:0]             scale;
  int                      error_cnt;
  int                      check_count;
  logic [5:0]              ens [8] = '{6'h20, 6'h20, 6'h30, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02};
  logic [15:0]             vals [8] = '{16'h0002, 16'hffff, 16'h0000, 16'hffff,
                                        16'h0002, 16'h0000, 16'h8000, 16'h0002};
  logic                    idle [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

  // 50 MHz clock; data wire pulled up, low if either side pulls
  initial clk = 1'b0;
  always #10 clk = ~clk;
  assign sda = !(sda_low || (!sda_oe_n && !sda_o));
  // Alert pin level as a pulled-up open-drain line would show it
  assign alert = alert_oe_n | alert_o;

  mon_alert mon_alert_inst (
    .SYS_CLK         (clk),
    .RST_N           (rst_n),
    .SCL_I           (scl),
    .SDA_I           (sda),
    .SDA_O           (sda_o),
    .SDA_OE_N        (sda_oe_n),
    .ALERT_O         (alert_o),
    .ALERT_OE_N      (alert_oe_n),
    .ADDR_STRAP_HIGH (strap_h),
    .ADDR_STRAP_LOW  (strap_l),
    .RESULTS         (res),
    .CONV_DONE       (conv_done),
    .SETUP           (setup),
    .SCALE           (scale)
  );
  host host_inst (
    .clk     (clk),
    .sda     (sda),
    .scl     (scl),
    .sda_low (sda_low)
  );

  // ----
  // Access tasks
  // ----
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] adr(input logic r);
    return {3'h4, strap_h, strap_l, r};
  endfunction : adr

  task automatic wr(input logic [2:0] p, input logic [15:0] d);
    logic a;
    host_inst.cond(1'b0);
    host_inst.send(adr(1'b0), a);
    host_inst.send({5'h00, p}, a);
    host_inst.send(d[15:8], a);
    host_inst.send(d[7:0], a);
    host_inst.cond(1'b1);
  endtask : wr

  // keep skips the pointer write, reading where the last write left it
  task automatic rd(input logic [2:0] p, input logic keep, output logic [15:0] d);
    logic a;
    if (!keep)
    begin
      host_inst.cond(1'b0);
      host_inst.send(adr(1'b0), a);
      host_inst.send({5'h00, p}, a);
    end
    host_inst.cond(1'b0);
    host_inst.send(adr(1'b1), a);
    host_inst.recv(8'hff, 1'b0, d[15:8]);
    host_inst.recv(8'hff, 1'b1, d[7:0]);
    host_inst.cond(1'b1);
  endtask : rd

  task automatic rchk(input logic [2:0] p, input logic [15:0] exp);
    logic [15:0] d;
    rd(p, 1'b0, d);
    chk(exp, d);
  endtask : rchk

  task automatic ping(input logic [7:0] b, input logic exp);
    logic a;
    host_inst.cond(1'b0);
    host_inst.send(b, a);
    host_inst.cond(1'b1);
    chk({15'h0000, exp}, {15'h0000, a});
  endtask : ping

  // Alert response read; rival bits model a competing lower address
  task automatic ara(input logic [7:0] rival, output logic [7:0] d);
    logic a;
    host_inst.cond(1'b0);
    host_inst.send(8'h19, a);
    host_inst.recv(rival, 1'b1, d);
    host_inst.cond(1'b1);
  endtask : ara

  task automatic conv(input logic [15:0] v);
    @(posedge clk)
    begin
      res       <= {v, v, v, v};
      conv_done <= 1'b1;
    end
    @(posedge clk) conv_done <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : conv

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // Hang guard, well past the expected 15k cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    stop_test;
  end

  // ----
  // Tests
  // ----
  initial
  begin : main
    logic [15:0] d;
    logic [7:0]  b;
    rst_n       = 1'b0;
    conv_done   = 1'b0;
    res         = {4{16'h0000}};
    strap_h     = 2'h0;
    strap_l     = 2'h0;
    error_cnt   = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(16'h0000, setup);
    chk(16'h0000, scale);
    for (int k = 4; k < 8; k++)
      rchk((k == 4) ? 3'h0 : k[2:0], 16'h0000);
    wr(3'h0, 16'h4127);
    wr(3'h5, 16'h0a00);
    chk(16'h4127, setup);
    chk(16'h0a00, scale);
    rd(3'h0, 1'b1, d);
    chk(16'h0a00, d);
    conv(16'h1f40);
    wr(3'h1, 16'h0000);
    for (int k = 1; k < 5; k++)
      rchk(k[2:0], 16'h1f40);
    $display("test registers done");
    for (int k = 0; k < 16; k++)
    begin
      @(posedge clk) {strap_h, strap_l} <= k[3:0];
      repeat (2) @(posedge clk);
      ping(adr(1'b0), 1'b1);
      ping(adr(1'b0) ^ 8'h02, 1'b0);
    end
    ping(8'h19, 1'b0);
    $display("test addresses done");
    wr(3'h7, 16'h0001);
    for (int k = 0; k < 8; k++)
    begin
      wr(3'h6, {ens[k], 10'h000});
      conv(vals[k]);
      chk({15'h0000, idle[k]}, {15'h0000, alert});
      rchk(3'h6, {ens[k], 5'h00, !idle[k], 1'b1, 3'h0});
    end
    $display("test limits done");
    wr(3'h6, 16'h0400);
    conv(16'h0000);
    chk(16'h0000, {15'h0000, alert});
    rchk(3'h6, 16'h0408);
    chk(16'h0001, {15'h0000, alert});
    $display("test ready done");
    conv(16'h0000);
    ara(8'h00, b);
    chk(16'h0000, {15'h0000, alert});
    ara(8'hff, b);
    chk(16'h009e, {8'h00, b});
    chk(16'h0001, {15'h0000, alert});
    $display("test alert response done");
    stop_test;
  end
endmodule : tb
